// ### logic/mbi_map.vh
`ifndef MBI_MAP_VH
`define MBI_MAP_VH
// ============================================================
// register byte offsets
`define MBI_OFF_CTRL    8'h00
`define MBI_OFF_INSTR   8'h04
`define MBI_OFF_INDEX   8'h08
`define MBI_OFF_BASE    8'h0C
`define MBI_OFF_PC      8'h10
`define MBI_OFF_STATUS  8'h14
`define MBI_OFF_MDATA   8'h18
`define MBI_OFF_EADDR   8'h1C
// ============================================================
// instruction fields
`define MBI_DISPLACEMENT_FIELD_MSB    4
`define MBI_BSEL_LSB    5
`define MBI_BSEL_MSB    7
`define MBI_IXSEL_BIT   8
`define MBI_IND_BIT     9
`define MBI_OP_LSB      11
`define MBI_OP_MSB      15
`define MBI_DISPLACEMENT_FIELD_LONG   5'h1F
// ============================================================
// operation codes
`define MBI_OP_SET      5'h10
`define MBI_OP_CLR      5'h11
`define MBI_OP_TST      5'h12
`define MBI_OP_INC      5'h13
// ============================================================
// control and status bits
`define MBI_CTRL_START  0
`define MBI_ST_BUSY     0
`define MBI_ST_ZERO     1
`define MBI_ST_PLUS     2
`define MBI_ST_LINK     3
`define MBI_ST_BADOP    4
`define MBI_ST_STATE    8
// ============================================================
// reset values, bus answers, timing
`define MBI_RST_WORD    16'h0000
`define MBI_RESP_OKAY   2'h0
`define MBI_RESP_SLVERR 2'h2
`define MBI_PHASE_DIV   4
`endif

// ### logic/mbi_phase_div.v
`timescale 1ns/1ps
`include "mbi_map.vh"

module mbi_phase_div #(
  parameter DIV = `MBI_PHASE_DIV
) (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // phase enable
  output wire phase_tick
);
  localparam [7:0] LAST = DIV[7:0] - 8'h01;

  reg [7:0] cnt_reg;
  reg       tick_reg;

  // ============================================================
  // one-cycle enable every DIV clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == LAST);
      if (cnt_reg == LAST)
        cnt_reg <= 8'h00;
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign phase_tick = tick_reg;
endmodule // mbi_phase_div

// ### logic/mbi_addend_alu.v
`timescale 1ns/1ps

module mbi_addend_alu (
  // operand
  input  wire [15:0] m_word,
  input  wire [2:0]  bit_sel,
  input  wire        byte_lo,
  // addend controls
  input  wire        force_one,
  input  wire        force_zero,
  input  wire        forced_carry_in,
  // results
  output wire [15:0] alu_out,
  output wire        sel_bit,
  output wire        link_out,
  output wire        zero_out,
  output wire        plus_out
);
  wire [3:0]  pos;
  wire [15:0] mask;
  wire [15:0] addend;
  wire [16:0] sum;

  // ============================================================
  // addend bus
  assign pos    = {~byte_lo, bit_sel};
  assign mask   = 16'h0001 << pos;
  assign addend = force_one  ? (m_word | mask) :
                  force_zero ? (m_word & ~mask) : m_word;
  assign sel_bit = |(m_word & mask);

  // ============================================================
  // alu adder with forced carry
  assign sum      = {1'b0, addend} + {16'h0000, forced_carry_in};
  assign alu_out  = sum[15:0];
  assign link_out = sum[16];
  assign zero_out = (sum[15:0] == 16'h0000);
  assign plus_out = ~sum[15];
endmodule // mbi_addend_alu

// ### logic/mbi_exec.v
`timescale 1ns/1ps
// Contract
// - set bit, even index: force chosen bit of upper byte 8-15 to one
// - set bit, odd index: force chosen bit of lower byte 0-7 to one
// - bit within the byte comes from instruction bits 5, 6 and 7
// - set bit copies the chosen bit's old value into zero first
// - without indexing the upper byte is the operand
// - addend logic forces bit to one; merged word goes back to memory
// - clear bit, even index: clear chosen bit of upper byte 8-15
// - clear bit, odd index: clear chosen bit of lower byte 0-7
// - clear bit copies the chosen bit's old value into zero first
// - clearing passes data over addend bus, only the chosen bit deselected
// - test bit selects like set, sets zero, leaves memory unchanged
// - increment passes data over addend bus with forced carry, result back
// - increment raises flag load so zero, plus and link take alu result
// - increment's first three states form the address as load register does
// - first state, direct and short displacement: add base, go to final state
`include "mbi_map.vh"

module mbi_exec #(
  parameter PHASE_DIV = `MBI_PHASE_DIV
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // core memory
  output reg  [15:0] mem_addr,
  output reg         mem_rd_en,
  output reg         mem_wr_en,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ready,
  // datapath strobes
  output wire        forced_carry_in,
  output wire        flag_load_strobe,
  output wire        final_state_phase_two
);
  // ============================================================
  // states and phases
  localparam [3:0] S1 = 4'b0001;
  localparam [3:0] S2 = 4'b0010;
  localparam [3:0] S3 = 4'b0100;
  localparam [3:0] S5 = 4'b1000;
  localparam [3:0] D1 = 4'b0001;
  localparam [3:0] D2 = 4'b0010;
  localparam [3:0] D3 = 4'b0100;
  localparam [3:0] D4 = 4'b1000;

  // ============================================================
  // declarations
  reg        aw_held_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rd_word;
  reg [15:0] instr_reg;
  reg [15:0] index_reg;
  reg [15:0] base_reg;
  reg [15:0] pc_reg;
  reg [15:0] m_reg;
  reg [15:0] w_reg;
  reg [15:0] l_reg;
  reg [15:0] q_reg;
  reg [15:0] r_reg;
  reg [3:0]  state_reg;
  reg [3:0]  phase_reg;
  reg        run_reg;
  reg        m_got_reg;
  reg        w_done_reg;
  reg        zero_reg;
  reg        plus_reg;
  reg        link_reg;
  reg        badop_reg;
  wire       wr_fire;
  wire       phase_tick;
  wire       is_set;
  wire       is_clr;
  wire       is_tst;
  wire       is_inc;
  wire       op_ok;
  wire       ind;
  wire       long_displacement_field;
  wire [15:0] displacement_field;
  wire [15:0] half_q;
  wire       in_d2_s5;
  wire       writes_back;
  wire       need_rd;
  wire       need_wr;
  wire       adv;
  wire       start_req;
  wire [15:0] alu_out;
  wire       sel_bit;
  wire       alu_link;
  wire       alu_zero;
  wire       alu_plus;

  // ============================================================
  // decode helpers
  function reg_known;
    input [7:0] addr;
    begin
      reg_known = (addr[1:0] == 2'h0) && (addr <= `MBI_OFF_EADDR);
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old_val[15:8],
                 strb[0] ? data[7:0] : old_val[7:0]};
    end
  endfunction

  function op_is;
    input [15:0] word;
    input [4:0]  code;
    begin
      op_is = (word[`MBI_OP_MSB:`MBI_OP_LSB] == code);
    end
  endfunction

  // ============================================================
  // axi4-lite write channel
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `MBI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= reg_known(aw_addr_reg) ? `MBI_RESP_OKAY : `MBI_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // operand registers are frozen while an instruction runs
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg <= `MBI_RST_WORD;
      index_reg <= `MBI_RST_WORD;
      base_reg  <= `MBI_RST_WORD;
    end else if (wr_fire && !run_reg) begin
      case (aw_addr_reg)
        `MBI_OFF_INSTR: instr_reg <= merge16(instr_reg, w_data_reg, w_strb_reg);
        `MBI_OFF_INDEX: index_reg <= merge16(index_reg, w_data_reg, w_strb_reg);
        `MBI_OFF_BASE:  base_reg  <= merge16(base_reg, w_data_reg, w_strb_reg);
        default:        instr_reg <= instr_reg;
      endcase
    end
  end

  // ============================================================
  // axi4-lite read channel
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always @* begin
    case (s_axi_araddr)
      `MBI_OFF_INSTR:  rd_word = {16'h0000, instr_reg};
      `MBI_OFF_INDEX:  rd_word = {16'h0000, index_reg};
      `MBI_OFF_BASE:   rd_word = {16'h0000, base_reg};
      `MBI_OFF_PC:     rd_word = {16'h0000, pc_reg};
      `MBI_OFF_STATUS: rd_word = {20'h00000, state_reg, 3'h0, badop_reg,
                                  link_reg, plus_reg, zero_reg, run_reg};
      `MBI_OFF_MDATA:  rd_word = {16'h0000, m_reg};
      `MBI_OFF_EADDR:  rd_word = {16'h0000, l_reg};
      default:         rd_word = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `MBI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= reg_known(s_axi_araddr) ? `MBI_RESP_OKAY : `MBI_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ============================================================
  // instruction decode
  assign is_set    = op_is(instr_reg, `MBI_OP_SET);
  assign is_clr    = op_is(instr_reg, `MBI_OP_CLR);
  assign is_tst    = op_is(instr_reg, `MBI_OP_TST);
  assign is_inc    = op_is(instr_reg, `MBI_OP_INC);
  assign op_ok     = is_set || is_clr || is_tst || is_inc;
  assign ind       = instr_reg[`MBI_IND_BIT];
  assign displacement_field      = {11'h000, instr_reg[`MBI_DISPLACEMENT_FIELD_MSB:0]};
  assign long_displacement_field = (instr_reg[`MBI_DISPLACEMENT_FIELD_MSB:0] == `MBI_DISPLACEMENT_FIELD_LONG);
  assign half_q    = {1'b0, q_reg[15:1]};
  assign start_req = wr_fire && (aw_addr_reg == `MBI_OFF_CTRL) && w_strb_reg[0] &&
                     w_data_reg[`MBI_CTRL_START] && !run_reg;

  // ============================================================
  // phase timing and memory stalls
  mbi_phase_div #(
    .DIV (PHASE_DIV)
  ) u_phase (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .phase_tick (phase_tick)
  );

  assign in_d2_s5    = run_reg && (state_reg == S5) && (phase_reg == D2);
  assign writes_back = is_set || is_clr || is_inc;
  assign need_rd     = run_reg && (state_reg != S1) && (phase_reg == D1) && !m_got_reg;
  assign need_wr     = run_reg && (state_reg == S5) && (phase_reg == D4) &&
                       writes_back && !w_done_reg;
  assign adv         = phase_tick && run_reg && !need_rd && !need_wr &&
                       !mem_rd_en && !mem_wr_en;

  assign forced_carry_in       = in_d2_s5 && is_inc;
  assign flag_load_strobe      = in_d2_s5 && is_inc;
  assign final_state_phase_two = in_d2_s5;

  // ============================================================
  // addend bus and alu
  mbi_addend_alu u_alu (
    .m_word          (m_reg),
    .bit_sel         (instr_reg[`MBI_BSEL_MSB:`MBI_BSEL_LSB]),
    .byte_lo         (q_reg[0]),
    .force_one       (is_set),
    .force_zero      (is_clr),
    .forced_carry_in (forced_carry_in),
    .alu_out         (alu_out),
    .sel_bit         (sel_bit),
    .link_out        (alu_link),
    .zero_out        (alu_zero),
    .plus_out        (alu_plus)
  );

  // ============================================================
  // state sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= S1;
      phase_reg  <= D1;
      run_reg    <= 1'b0;
      m_got_reg  <= 1'b0;
      w_done_reg <= 1'b0;
      pc_reg     <= `MBI_RST_WORD;
      m_reg      <= `MBI_RST_WORD;
      w_reg      <= `MBI_RST_WORD;
      l_reg      <= `MBI_RST_WORD;
      q_reg      <= `MBI_RST_WORD;
      r_reg      <= `MBI_RST_WORD;
      zero_reg   <= 1'b0;
      plus_reg   <= 1'b0;
      link_reg   <= 1'b0;
      badop_reg  <= 1'b0;
      mem_addr   <= `MBI_RST_WORD;
      mem_rd_en  <= 1'b0;
      mem_wr_en  <= 1'b0;
      mem_wdata  <= `MBI_RST_WORD;
    end else begin
      if (wr_fire && !run_reg && (aw_addr_reg == `MBI_OFF_PC))
        pc_reg <= merge16(pc_reg, w_data_reg, w_strb_reg);
      if (start_req) begin
        run_reg   <= op_ok;
        badop_reg <= !op_ok;
      end
      // memory read and write handshakes
      if (mem_rd_en && mem_ready) begin
        mem_rd_en <= 1'b0;
        m_reg     <= mem_rdata;
        m_got_reg <= 1'b1;
      end else if (need_rd && !mem_rd_en) begin
        mem_rd_en <= 1'b1;
        mem_addr  <= l_reg;
      end
      if (mem_wr_en && mem_ready) begin
        mem_wr_en  <= 1'b0;
        w_done_reg <= 1'b1;
      end else if (need_wr && !mem_wr_en) begin
        mem_wr_en <= 1'b1;
        mem_addr  <= l_reg;
        mem_wdata <= m_reg;
      end
      if (adv) begin
        case (phase_reg)
          D1:      phase_reg <= D2;
          D2:      phase_reg <= D3;
          D3:      phase_reg <= D4;
          D4:      phase_reg <= D1;
          default: phase_reg <= D1;
        endcase
        if (phase_reg == D4) begin
          m_got_reg  <= 1'b0;
          w_done_reg <= 1'b0;
        end
        case (state_reg)
          // address forming shared with load register
          S1: begin
            if (phase_reg == D2) begin
              pc_reg <= pc_reg + 16'h0001;
              q_reg  <= instr_reg[`MBI_IXSEL_BIT] ? index_reg : 16'h0000;
              r_reg  <= base_reg;
            end
            if (phase_reg == D3)
              w_reg <= ind ? displacement_field : displacement_field + half_q;
            if (phase_reg == D4) begin
              if (long_displacement_field) begin
                w_reg     <= pc_reg;
                l_reg     <= pc_reg;
                state_reg <= S2;
              end else begin
                w_reg     <= w_reg + r_reg;
                l_reg     <= w_reg + r_reg;
                state_reg <= ind ? S3 : S5;
              end
            end
          end
          S2: begin
            if (phase_reg == D2)
              pc_reg <= pc_reg + 16'h0001;
            if (phase_reg == D3)
              w_reg <= ind ? m_reg : m_reg + half_q;
            if (phase_reg == D4) begin
              w_reg     <= w_reg + r_reg;
              l_reg     <= w_reg + r_reg;
              state_reg <= ind ? S3 : S5;
            end
          end
          S3: begin
            if (phase_reg == D3)
              w_reg <= m_reg + half_q;
            if (phase_reg == D4) begin
              l_reg     <= w_reg;
              state_reg <= S5;
            end
          end
          S5: begin
            if (phase_reg == D2) begin
              if (is_inc) begin
                m_reg    <= alu_out;
                zero_reg <= alu_zero;
                plus_reg <= alu_plus;
                link_reg <= alu_link;
              end else begin
                zero_reg <= sel_bit;
                if (!is_tst)
                  m_reg <= alu_out;
              end
            end
            if (phase_reg == D4) begin
              l_reg     <= pc_reg;
              state_reg <= S1;
              run_reg   <= 1'b0;
            end
          end
          default: state_reg <= S1;
        endcase
      end
    end
  end
endmodule // mbi_exec

// ### verif/mbi_mem_model.sv
`timescale 1ns/1ps
// ============================================================
// core memory on a same-clock request and ready handshake
module mbi_mem_model (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // request
  input  wire [15:0] mem_addr,
  input  wire        mem_rd_en,
  input  wire        mem_wr_en,
  input  wire [15:0] mem_wdata,
  input  wire        slow,
  // answer
  output wire [15:0] mem_rdata,
  output wire        mem_ready
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_cnt;
  logic [15:0] junk;
  wire         req = mem_rd_en || mem_wr_en;
  // slow mode answers after three wait cycles
  assign mem_ready = req && (!slow || wait_cnt == 2'h3);
  // data lines churn out of reset whenever no read is answered, and hold C3C3 in reset
  assign mem_rdata = (mem_rd_en && mem_ready) ? mem[mem_addr[7:0]] : junk;
  always @(posedge aclk) begin
    junk <= aresetn ? ~junk : 16'hC3C3;
    wait_cnt <= (!aresetn || !req || mem_ready) ? 2'h0 : wait_cnt + 2'h1;
    if (mem_wr_en && mem_ready)
      mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule // mbi_mem_model

// ### verif/mbi_exec_assertions.sv
`timescale 1ns/1ps
// ============================================================
// checker on memory requests and datapath strobes
module mbi_exec_assertions #(
  parameter PHASE_DIV = 4
) (
  input wire        aclk,
  input wire        aresetn,
  input wire [15:0] mem_addr,
  input wire        mem_rd_en,
  input wire        mem_wr_en,
  input wire [15:0] mem_wdata,
  input wire        mem_ready,
  input wire        forced_carry_in,
  input wire        flag_load_strobe,
  input wire        final_state_phase_two
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the execute phase in clocks
  reg [8:0] fp2_cnt;
  always @(posedge aclk) begin
    if (!aresetn || !final_state_phase_two)
      fp2_cnt <= 9'h000;
    else
      fp2_cnt <= fp2_cnt + 9'h001;
  end
  sequence s_inc_end;
    $fell(forced_carry_in);
  endsequence
  sequence s_wr_wait;
    mem_wr_en && !mem_ready;
  endsequence
  property p_carry_final;
    forced_carry_in |-> final_state_phase_two;
  endproperty
  property p_flag_carry;
    flag_load_strobe == forced_carry_in;
  endproperty
  property p_phase_len;
    $fell(final_state_phase_two) |-> fp2_cnt == PHASE_DIV;
  endproperty
  property p_inc_write;
    s_inc_end |-> ##[1:400] mem_wr_en;
  endproperty
  property p_quiet_d2;
    final_state_phase_two |-> !mem_rd_en && !mem_wr_en;
  endproperty
  property p_wr_hold;
    s_wr_wait |=> mem_wr_en && $stable(mem_addr) && $stable(mem_wdata);
  endproperty
  property p_rd_hold;
    mem_rd_en && !mem_ready |=> mem_rd_en && $stable(mem_addr);
  endproperty
  property p_no_rw;
    !(mem_rd_en && mem_wr_en);
  endproperty
  a_carry_final: assert property (p_carry_final)
    else $error("carry outside execute phase");
  a_flag_carry: assert property (p_flag_carry)
    else $error("flag load apart from carry");
  a_phase_len: assert property (p_phase_len)
    else $error("execute phase length wrong");
  a_inc_write: assert property (p_inc_write)
    else $error("increment not written back");
  a_quiet_d2: assert property (p_quiet_d2)
    else $error("memory busy in execute phase");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write request dropped early");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read request dropped early");
  a_no_rw: assert property (p_no_rw)
    else $error("read and write together");
endmodule // mbi_exec_assertions

bind mbi_exec mbi_exec_assertions #(.PHASE_DIV(PHASE_DIV)) mbi_exec_assertions_inst (
  .aclk, .aresetn, .mem_addr, .mem_rd_en, .mem_wr_en, .mem_wdata, .mem_ready,
  .forced_carry_in, .flag_load_strobe, .final_state_phase_two
);

// ### verif/mbi_exec_tb.sv
`timescale 1ns/1ps
`include "mbi_map.vh"
// ============================================================
// bench top
module mbi_exec_tb;
  logic        aclk, aresetn, slow;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] maddr, mwdata, mrdata;
  wire         mrd, mwr, mready;
  logic [15:0] seed;
  int          miscompares, comparisons;

  mbi_exec #(.PHASE_DIV(2)) mbi_exec_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_addr(maddr), .mem_rd_en(mrd),
    .mem_wr_en(mwr), .mem_wdata(mwdata), .mem_rdata(mrdata), .mem_ready(mready),
    .forced_carry_in(), .flag_load_strobe(), .final_state_phase_two()
  );
  mbi_mem_model mbi_mem_model_inst (
    .aclk(aclk), .aresetn(aresetn), .mem_addr(maddr), .mem_rd_en(mrd), .mem_wr_en(mwr),
    .mem_wdata(mwdata), .slow(slow), .mem_rdata(mrdata), .mem_ready(mready)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ============================================================
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // result word, then link, plus, zero
  function automatic logic [18:0] expect_op(input logic [4:0] op, input logic [2:0] bsel,
                                            input logic [15:0] q, input logic [15:0] old);
    logic [3:0]  pos;
    logic [15:0] m;
    logic [16:0] s;
    pos = {~q[0], bsel};
    m = 16'h0001 << pos;
    s = {1'b0, old} + 17'h00001;
    case (op)
      `MBI_OP_SET: expect_op = {old | m, 2'h0, old[pos]};
      `MBI_OP_CLR: expect_op = {old & ~m, 2'h0, old[pos]};
      `MBI_OP_TST: expect_op = {old, 2'h0, old[pos]};
      default: expect_op = {s[15:0], s[16], ~s[15], s[15:0] == 16'h0000};
    endcase
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("mismatch at %0t: %s timed out", $time, what);
    wrap_up();
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s resp %h want %h", $time, what, got, exp);
    end
  endtask

  // ============================================================
  // register bus master
  task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {seed, d};
    awprot <= seed[2:0];
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    if (n >= 50) hang("write");
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arprot <= seed[2:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    if (n >= 50) hang("read");
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // ============================================================
  // one instruction from set-up to result check
  task automatic run_op(input logic [4:0] op, input logic [4:0] displacement_field, input logic [2:0] bsel,
                        input logic ix, input logic [15:0] q, input logic [15:0] base,
                        input logic [15:0] old, input logic ind);
    logic [18:0] e;
    logic [15:0] ea, pc, v, pa;
    logic [2:0]  m;
    logic [1:0]  r;
    int          n;
    pc = (displacement_field == 5'h1F) ? 16'h00F2 : 16'h00F1;
    // indirect ops fetch a pointer word at pa, then add half the index
    pa = ((displacement_field == 5'h1F) ? 16'h0030 : {11'h000, displacement_field}) + base;
    ea = (ind ? 16'h0060 : pa) + (ix ? q >> 1 : 16'h0000);
    mbi_mem_model_inst.mem[8'hF1] = 16'h0030;
    mbi_mem_model_inst.mem[pa[7:0]] = 16'h0060;
    mbi_mem_model_inst.mem[ea[7:0]] = old;
    e = expect_op(op, bsel, ix ? q : 16'h0000, old);
    m = (op == `MBI_OP_INC) ? 3'h7 : 3'h1;
    axi_write(`MBI_OFF_INSTR, {op, 1'b0, ind, ix, bsel, displacement_field}, r);
    axi_write(`MBI_OFF_INDEX, q, r);
    axi_write(`MBI_OFF_BASE, base, r);
    axi_write(`MBI_OFF_PC, 16'h00F0, r);
    axi_write(`MBI_OFF_CTRL, 16'h0001, r);
    n = 0;
    do begin
      axi_read(`MBI_OFF_STATUS, v, r);
      n++;
    end while (v[`MBI_ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) hang("busy");
    check_word(mbi_mem_model_inst.mem[ea[7:0]], e[18:3], "memory");
    check_word({13'h0000, v[3:1] & m}, {13'h0000, e[2:0] & m}, "flags");
    axi_read(`MBI_OFF_MDATA, v, r);
    check_word(v, e[18:3], "data register");
    axi_read(`MBI_OFF_PC, v, r);
    check_word(v, pc, "program counter");
    axi_read(`MBI_OFF_EADDR, v, r);
    check_word(v, pc, "address latch");
  endtask

  // ============================================================
  // main sequence
  initial begin
    logic [15:0] a, b, v;
    logic [1:0]  r;
    miscompares = 0;
    comparisons = 0;
    seed = 16'h78B4;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, slow} = 6'h00;
    {awaddr, araddr} = 16'h0000;
    {awprot, arprot} = 6'h00;
    wstrb = 4'hF;
    wdata = 32'h00000000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // no index with odd index value, then odd index: both byte ends
    for (int k = 0; k < 8; k++)
      run_op(`MBI_OP_SET + k[1:0], 5'h03, k[2] ? 3'h7 : 3'h0, k[2], 16'h0005, 16'h0020,
             16'h5AA5, 1'b0);
    run_op(`MBI_OP_INC, 5'h1F, 3'h0, 1'b1, 16'h0004, 16'h0010, 16'hFFFF, 1'b1);
    run_op(`MBI_OP_INC, 5'h00, 3'h0, 1'b0, 16'h0000, 16'h0000, 16'h7FFF, 1'b0);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr_next(seed);
      a = seed;
      seed = lfsr_next(seed);
      b = seed;
      slow <= a[15];
      run_op(5'h10 + a[1:0], (a[6:2] == 5'h1F) ? 5'h00 : a[6:2], a[9:7], a[10],
             {8'h00, b[7:0]}, {10'h000, b[13:8]}, a ^ b, b[14]);
    end
    axi_write(8'h20, 16'hFFFF, r);
    check_resp(r, `MBI_RESP_SLVERR, "unmapped write");
    axi_read(8'h20, v, r);
    check_resp(r, `MBI_RESP_SLVERR, "unmapped read");
    check_word(v, 16'h0000, "unmapped data");
    // unknown opcode: start refused, busy stays low, bad-opcode bit set
    axi_write(`MBI_OFF_INSTR, 16'h0000, r);
    axi_write(`MBI_OFF_CTRL, 16'h0001, r);
    axi_read(`MBI_OFF_STATUS, v, r);
    check_word(v & 16'h0011, 16'h0010, "bad opcode");
    wrap_up();
  end
endmodule // mbi_exec_tb
